/* rtl/i2c_engine_map.svh */
`ifndef I2C_ENGINE_MAP_SVH
`define I2C_ENGINE_MAP_SVH
`define CLK_NS 10
`define T_STD_NS 10000
`define T_FAST_NS 2500
`define T_HS_NS 1201
`define HALF_CYC(t) 10'((((t) / 2) + `CLK_NS - 1) / `CLK_NS)
`define SPD_STD 2'h0
`define SPD_FAST 2'h1
`define BIT_LAST 4'h7
`define ACK_SLOT 4'h8
`define BYTE_END 4'h9
`define GCALL_ADDR 7'h00
`define RW_WRITE 1'b0
`define FIFO_W 8
`define FIFO_D 8
`endif

/* rtl/i2c_engine_pkg.sv */
package i2c_engine_pkg;
  typedef enum logic [3:0] {
    M_IDLE, M_WAIT, M_START, M_LOW, M_HIGH, M_RS, M_RSH, M_STOP_A, M_STOP_B
  } mst_state_t;
endpackage

/* rtl/fifo_if.sv */
`timescale 1ns/1ps
interface fifo_if #(parameter int W = 8);
  logic         in_valid;
  logic         in_ready;
  logic [W-1:0] in_data;
  logic         out_valid;
  logic         out_ready;
  logic [W-1:0] out_data;
  modport fifo (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
  modport user (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface

/* rtl/byte_fifo.sv */
`timescale 1ns/1ps
module byte_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input wire logic core_clk,
  input wire logic rst_n,
  fifo_if.fifo     q
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0]   cnt_r, cnt_nxt;
  logic          in_ready_r, in_ready_nxt, out_valid_r, out_valid_nxt;
  logic          push, pull;

  assign push        = q.in_valid && in_ready_r;
  assign pull        = q.out_ready && out_valid_r;
  assign q.in_ready  = in_ready_r;
  assign q.out_valid = out_valid_r;
  assign q.out_data  = mem[rp_r];

  always_comb begin
    wp_nxt        = push ? wp_r + AW'(1) : wp_r;
    rp_nxt        = pull ? rp_r + AW'(1) : rp_r;
    cnt_nxt       = cnt_r + (AW+1)'(push) - (AW+1)'(pull);
    // ready and valid come from flops so the top sees registered handshakes
    in_ready_nxt  = (cnt_nxt != (AW+1)'(D));
    out_valid_nxt = (cnt_nxt != '0);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_r        <= '0;
      rp_r        <= '0;
      cnt_r       <= '0;
      in_ready_r  <= 1'b1;
      out_valid_r <= 1'b0;
    end else begin
      wp_r        <= wp_nxt;
      rp_r        <= rp_nxt;
      cnt_r       <= cnt_nxt;
      in_ready_r  <= in_ready_nxt;
      out_valid_r <= out_valid_nxt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wp_r] <= q.in_data;
    end
  end

  a_fifo_bound: assert property (@(posedge core_clk) disable iff (!rst_n)
    cnt_r <= (AW+1)'(D)) else $error("fifo count above depth");
endmodule

/* rtl/i2c_engine.sv */
`timescale 1ns/1ps
`include "i2c_engine_map.svh"
module i2c_engine (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       enable,
  input  wire logic [1:0] spd,
  input  wire logic [6:0] own_addr,
  input  wire logic       go,
  input  wire logic       stop_req,
  input  wire logic       restart_req,
  input  wire logic       nack_next,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready,
  input  wire logic       scl_i,
  output logic            scl_o,
  output logic            scl_oe,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe,
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  output logic            ev_byte,
  output logic            ack_rcvd,
  output logic            ev_arb_lost,
  output logic            ev_addr_match,
  output logic            ev_gen_call,
  output logic            bus_busy,
  output logic            is_master
);
  i2c_engine_pkg::mst_state_t mst_r, mst_nxt;
  logic [9:0] tc_r, tc_nxt, half;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] rx_r, rx_nxt, tx_r, tx_nxt, rx_data_r, rx_data_nxt;
  logic       master_r, master_nxt, busy_r, busy_nxt, xmit_r, xmit_nxt;
  logic       first_r, first_nxt, addressed_r, addressed_nxt, rw_r, rw_nxt;
  logic       load_r, load_nxt, sda_oe_r, sda_oe_nxt, scl_oe_r, scl_oe_nxt;
  logic       rx_valid_r, rx_valid_nxt, ev_byte_r, ev_byte_nxt, ack_r, ack_nxt;
  logic       ev_arb_r, ev_arb_nxt, ev_match_r, ev_match_nxt, ev_gcall_r, ev_gcall_nxt;
  logic       line_lo_r, pop, gcall, hit, tc_end;
  logic       scl_m, scl_s, scl_p, sda_m, sda_s, sda_p;
  logic       scl_rise, scl_fall, start_det, stop_det;

  fifo_if #(.W(`FIFO_W)) f ();
  assign f.in_valid  = tx_valid;
  assign f.in_data   = tx_data;
  assign f.out_ready = pop;
  assign tx_ready    = f.in_ready;

  byte_fifo #(.W(`FIFO_W), .D(`FIFO_D)) u_fifo (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .q        (f.fifo)
  );

  // first stage feeds only the second; edges look at stages two and three
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_p <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_p <= 1'b1;
    end else begin
      scl_m <= scl_i;
      scl_s <= scl_m;
      scl_p <= scl_s;
      sda_m <= sda_i;
      sda_s <= sda_m;
      sda_p <= sda_s;
    end
  end

  assign scl_rise  = scl_s && !scl_p;
  assign scl_fall  = !scl_s && scl_p;
  assign start_det = scl_s && scl_p && sda_p && !sda_s;
  assign stop_det  = scl_s && scl_p && !sda_p && sda_s;
  assign tc_end    = (tc_r + 10'h001 >= half);

  always_comb begin
    case (spd)
      `SPD_STD:  half = `HALF_CYC(`T_STD_NS);
      `SPD_FAST: half = `HALF_CYC(`T_FAST_NS);
      default:   half = `HALF_CYC(`T_HS_NS);
    endcase
  end

  always_comb begin
    mst_nxt       = mst_r;
    tc_nxt        = tc_r;
    master_nxt    = master_r;
    busy_nxt      = busy_r;
    cnt_nxt       = cnt_r;
    rx_nxt        = rx_r;
    tx_nxt        = tx_r;
    xmit_nxt      = xmit_r;
    first_nxt     = first_r;
    addressed_nxt = addressed_r;
    rw_nxt        = rw_r;
    load_nxt      = load_r;
    sda_oe_nxt    = sda_oe_r;
    scl_oe_nxt    = scl_oe_r;
    rx_valid_nxt  = 1'b0;
    rx_data_nxt   = rx_data_r;
    ev_byte_nxt   = 1'b0;
    ack_nxt       = ack_r;
    ev_arb_nxt    = 1'b0;
    ev_match_nxt  = 1'b0;
    ev_gcall_nxt  = 1'b0;
    pop           = 1'b0;
    gcall         = 1'b0;
    hit           = 1'b0;
    if (start_det) begin
      busy_nxt = 1'b1;
    end else if (stop_det) begin
      busy_nxt = 1'b0;
    end
    // bit engine follows the bus edges in both roles
    if (start_det) begin
      cnt_nxt       = 4'h0;
      first_nxt     = 1'b1;
      addressed_nxt = 1'b0;
      xmit_nxt      = master_r;
      load_nxt      = 1'b0;
    end else if (stop_det) begin
      cnt_nxt       = 4'h0;
      first_nxt     = 1'b0;
      addressed_nxt = 1'b0;
      xmit_nxt      = 1'b0;
      load_nxt      = 1'b0;
    end else if (scl_rise) begin
      rx_nxt  = {rx_r[6:0], sda_s};
      cnt_nxt = cnt_r + 4'h1;
      if (master_r && xmit_r && cnt_r <= `BIT_LAST && !sda_oe_r && !sda_s) begin
        master_nxt = 1'b0;
        xmit_nxt   = 1'b0;
        mst_nxt    = i2c_engine_pkg::M_IDLE;
        tc_nxt     = 10'h000;
        ev_arb_nxt = 1'b1;
      end
      if (cnt_r == `BIT_LAST) begin
        rx_valid_nxt = !xmit_r;
        rx_data_nxt  = {rx_r[6:0], sda_s};
        if (first_r) begin
          rw_nxt        = sda_s;
          gcall         = (rx_r[6:0] == `GCALL_ADDR) && (sda_s == `RW_WRITE);
          hit           = !master_nxt && (rx_r[6:0] == own_addr || gcall);
          addressed_nxt = hit;
          ev_match_nxt  = hit;
          ev_gcall_nxt  = gcall && hit;
        end
      end
      if (cnt_r == `ACK_SLOT) begin
        ack_nxt     = !sda_s;
        ev_byte_nxt = 1'b1;
        first_nxt   = 1'b0;
        if (!master_r && xmit_r && sda_s) begin
          xmit_nxt      = 1'b0;
          addressed_nxt = 1'b0;
        end
      end
    end else if (scl_fall) begin
      if (cnt_r == `BYTE_END) begin
        cnt_nxt    = 4'h0;
        xmit_nxt   = master_r ? (rw_r == `RW_WRITE) : (addressed_r && rw_r);
        load_nxt   = xmit_nxt;
        sda_oe_nxt = 1'b0;
      end else if (cnt_r == `ACK_SLOT) begin
        sda_oe_nxt = !xmit_r && (master_r ? !nack_next : addressed_r);
      end else if (cnt_r != 4'h0) begin
        tx_nxt     = {tx_r[6:0], 1'b0};
        sda_oe_nxt = xmit_r && !tx_r[6];
      end else begin
        sda_oe_nxt = xmit_r && !tx_r[7];
      end
    end
    // an empty fifo keeps SCL low until the next byte arrives
    if (load_r && f.out_valid && !start_det && !stop_det) begin
      tx_nxt     = f.out_data;
      pop        = 1'b1;
      load_nxt   = 1'b0;
      sda_oe_nxt = !f.out_data[7];
    end
    if (!ev_arb_nxt) begin
      case (mst_r)
        i2c_engine_pkg::M_IDLE: begin
          if (go && f.out_valid && !load_r) begin
            mst_nxt = i2c_engine_pkg::M_WAIT;
          end
        end
        i2c_engine_pkg::M_WAIT: begin
          if (!f.out_valid || load_r) begin
            mst_nxt = i2c_engine_pkg::M_IDLE;
          end else if (!busy_r) begin
            master_nxt = 1'b1;
            tx_nxt     = f.out_data;
            pop        = 1'b1;
            sda_oe_nxt = 1'b1;
            tc_nxt     = 10'h000;
            mst_nxt    = i2c_engine_pkg::M_START;
          end
        end
        i2c_engine_pkg::M_START: begin
          if (tc_end) begin
            scl_oe_nxt = 1'b1;
            tc_nxt     = 10'h000;
            mst_nxt    = i2c_engine_pkg::M_LOW;
          end else begin
            tc_nxt = tc_r + 10'h001;
          end
        end
        i2c_engine_pkg::M_LOW: begin
          if (load_r) begin
            tc_nxt = 10'h000;
          end else if (tc_end) begin
            scl_oe_nxt = 1'b0;
            tc_nxt     = 10'h000;
            mst_nxt    = i2c_engine_pkg::M_HIGH;
          end else begin
            tc_nxt = tc_r + 10'h001;
          end
        end
        i2c_engine_pkg::M_HIGH: begin
          if (!scl_s) begin
            tc_nxt = 10'h000;
          end else if (tc_end) begin
            tc_nxt     = 10'h000;
            scl_oe_nxt = 1'b1;
            mst_nxt    = i2c_engine_pkg::M_LOW;
            if (cnt_r == `BYTE_END) begin
              if (stop_req || (rw_r == `RW_WRITE && !ack_r)) begin
                mst_nxt  = i2c_engine_pkg::M_STOP_A;
                cnt_nxt  = 4'h0;
                xmit_nxt = 1'b0;
              end else if (restart_req) begin
                mst_nxt  = i2c_engine_pkg::M_RS;
                cnt_nxt  = 4'h0;
                xmit_nxt = 1'b0;
              end
            end
          end else begin
            tc_nxt = tc_r + 10'h001;
          end
        end
        i2c_engine_pkg::M_RS: begin
          sda_oe_nxt = 1'b0;
          if (tc_end) begin
            scl_oe_nxt = 1'b0;
            tc_nxt     = 10'h000;
            mst_nxt    = i2c_engine_pkg::M_RSH;
          end else begin
            tc_nxt = tc_r + 10'h001;
          end
        end
        i2c_engine_pkg::M_RSH: begin
          if (!scl_s) begin
            tc_nxt = 10'h000;
          end else if (tc_end && f.out_valid) begin
            sda_oe_nxt = 1'b1;
            tx_nxt     = f.out_data;
            pop        = 1'b1;
            tc_nxt     = 10'h000;
            mst_nxt    = i2c_engine_pkg::M_START;
          end else if (!tc_end) begin
            tc_nxt = tc_r + 10'h001;
          end
        end
        i2c_engine_pkg::M_STOP_A: begin
          scl_oe_nxt = 1'b1;
          sda_oe_nxt = 1'b1;
          if (tc_end) begin
            scl_oe_nxt = 1'b0;
            tc_nxt     = 10'h000;
            mst_nxt    = i2c_engine_pkg::M_STOP_B;
          end else begin
            tc_nxt = tc_r + 10'h001;
          end
        end
        i2c_engine_pkg::M_STOP_B: begin
          sda_oe_nxt = 1'b1;
          if (!scl_s) begin
            tc_nxt = 10'h000;
          end else if (tc_end) begin
            sda_oe_nxt = 1'b0;
            master_nxt = 1'b0;
            tc_nxt     = 10'h000;
            mst_nxt    = i2c_engine_pkg::M_IDLE;
          end else begin
            tc_nxt = tc_r + 10'h001;
          end
        end
        default: begin
          mst_nxt = i2c_engine_pkg::M_IDLE;
        end
      endcase
    end
    if (!master_nxt) begin
      scl_oe_nxt = load_nxt;
    end
    if (!enable) begin
      mst_nxt       = i2c_engine_pkg::M_IDLE;
      master_nxt    = 1'b0;
      tc_nxt        = 10'h000;
      xmit_nxt      = 1'b0;
      addressed_nxt = 1'b0;
      load_nxt      = 1'b0;
      pop           = 1'b0;
      sda_oe_nxt    = 1'b0;
      scl_oe_nxt    = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mst_r       <= i2c_engine_pkg::M_IDLE;
      tc_r        <= 10'h000;
      master_r    <= 1'b0;
      busy_r      <= 1'b0;
      cnt_r       <= 4'h0;
      rx_r        <= 8'h00;
      tx_r        <= 8'h00;
      xmit_r      <= 1'b0;
      first_r     <= 1'b0;
      addressed_r <= 1'b0;
      rw_r        <= 1'b0;
      load_r      <= 1'b0;
      sda_oe_r    <= 1'b0;
      scl_oe_r    <= 1'b0;
      rx_valid_r  <= 1'b0;
      rx_data_r   <= 8'h00;
      ev_byte_r   <= 1'b0;
      ack_r       <= 1'b0;
      ev_arb_r    <= 1'b0;
      ev_match_r  <= 1'b0;
      ev_gcall_r  <= 1'b0;
      line_lo_r   <= 1'b0;
    end else begin
      mst_r       <= mst_nxt;
      tc_r        <= tc_nxt;
      master_r    <= master_nxt;
      busy_r      <= busy_nxt;
      cnt_r       <= cnt_nxt;
      rx_r        <= rx_nxt;
      tx_r        <= tx_nxt;
      xmit_r      <= xmit_nxt;
      first_r     <= first_nxt;
      addressed_r <= addressed_nxt;
      rw_r        <= rw_nxt;
      load_r      <= load_nxt;
      sda_oe_r    <= sda_oe_nxt;
      scl_oe_r    <= scl_oe_nxt;
      rx_valid_r  <= rx_valid_nxt;
      rx_data_r   <= rx_data_nxt;
      ev_byte_r   <= ev_byte_nxt;
      ack_r       <= ack_nxt;
      ev_arb_r    <= ev_arb_nxt;
      ev_match_r  <= ev_match_nxt;
      ev_gcall_r  <= ev_gcall_nxt;
      line_lo_r   <= 1'b0;
    end
  end

  assign scl_o         = line_lo_r;
  assign sda_o         = line_lo_r;
  assign scl_oe        = scl_oe_r;
  assign sda_oe        = sda_oe_r;
  assign rx_valid      = rx_valid_r;
  assign rx_data       = rx_data_r;
  assign ev_byte       = ev_byte_r;
  assign ack_rcvd      = ack_r;
  assign ev_arb_lost   = ev_arb_r;
  assign ev_addr_match = ev_match_r;
  assign ev_gen_call   = ev_gcall_r;
  assign bus_busy      = busy_r;
  assign is_master     = master_r;

  a_release_off: assert property (@(posedge core_clk) disable iff (!rst_n)
    !enable |=> !sda_oe_r && !scl_oe_r) else $error("lines held while disabled");
  a_never_high: assert property (@(posedge core_clk) disable iff (!rst_n)
    !scl_o && !sda_o) else $error("line driven high");
  a_busy_start: assert property (@(posedge core_clk) disable iff (!rst_n)
    start_det |=> busy_r) else $error("busy not set by start");
  a_busy_stop: assert property (@(posedge core_clk) disable iff (!rst_n)
    stop_det |=> !busy_r) else $error("busy not cleared by stop");
  a_start_free: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(master_r) |-> !$past(busy_r)) else $error("start on busy bus");
  a_stretch_wait: assert property (@(posedge core_clk) disable iff (!rst_n)
    (mst_r == i2c_engine_pkg::M_HIGH && !scl_s) |=> tc_r == 10'h000)
    else $error("clock ran while scl held low");
  a_arb_drop: assert property (@(posedge core_clk) disable iff (!rst_n)
    ev_arb_lost |-> !master_r && mst_r == i2c_engine_pkg::M_IDLE)
    else $error("master kept after arbitration loss");
  a_ack_own: assert property (@(posedge core_clk) disable iff (!rst_n)
    (enable && !master_r && scl_fall && cnt_r == `ACK_SLOT && !xmit_r)
    |=> sda_oe_r == addressed_r) else $error("slave ack not tied to match");
  a_sda_steady: assert property (@(posedge core_clk) disable iff (!rst_n)
    (enable && master_r && mst_r == i2c_engine_pkg::M_HIGH && scl_s && scl_p)
    |=> $stable(sda_oe_r)) else $error("sda moved while scl high");
  a_msb_first: assert property (@(posedge core_clk) disable iff (!rst_n)
    (pop && load_r) |=> sda_oe_r == !$past(f.out_data[7]))
    else $error("first bit is not the msb");
endmodule

/* tb/i2c_slave_model.sv */
`timescale 1ns/1ps
module i2c_slave_model #(
  parameter logic [6:0] ADDR = 7'h52
) (
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic stretch,
  output logic      sda_low,
  output logic      scl_low
);
  logic [7:0] sh;
  logic [7:0] got[$];
  int         n;
  logic       act;
  initial begin
    sda_low = 1'b0;
    scl_low = 1'b0;
    act = 1'b0;
    sh = 8'h00;
    n = 0;
  end
  // a restart looks the same as a start here, so it also drops the old transfer
  always @(negedge sda) if (scl) begin
    act = 1'b1;
    n = 0;
    got.delete();
  end
  always @(posedge sda) if (scl) act = 1'b0;
  always @(posedge scl) if (act && n < 8) begin
    sh = {sh[6:0], sda};
    n++;
  end
  always @(negedge scl) if (act) begin
    if (n == 8) begin
      if (got.size() > 0 || sh[7:1] == ADDR) begin
        got.push_back(sh);
        sda_low = 1'b1;
      end
      n = 9;
      if (stretch) begin
        scl_low = 1'b1;
        #2000 scl_low = 1'b0;
      end
    end else if (n == 9) begin
      sda_low = 1'b0;
      n = 0;
    end
  end
endmodule

/* tb/i2c_engine_test.sv */
`timescale 1ns/1ps
module i2c_engine_test;
  logic core_clk, rst_n, enable, go, stop_req, restart_req, nack_next, tx_valid;
  logic [1:0] spd;
  logic [6:0] own_addr;
  logic [7:0] tx_data, rx_data;
  logic tx_ready, scl_o, scl_oe, sda_o, sda_oe, rx_valid, ev_byte, ack_rcvd;
  logic ev_arb_lost, ev_addr_match, ev_gen_call, bus_busy, is_master;
  logic m_sda_low, m_scl_low, tb_sda_low, tb_scl_low, stretch;
  wire  scl = !(scl_oe | m_scl_low | tb_scl_low);
  wire  sda = !(sda_oe | m_sda_low | tb_sda_low);
  int   error_cnt, checks_done, cyc, n_match, n_gc, n_rx, n_arb;

  i2c_engine u_i2c_engine (.core_clk(core_clk), .rst_n(rst_n), .enable(enable), .spd(spd),
    .own_addr(own_addr), .go(go), .stop_req(stop_req), .restart_req(restart_req),
    .nack_next(nack_next), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .rx_valid(rx_valid), .rx_data(rx_data), .ev_byte(ev_byte),
    .ack_rcvd(ack_rcvd), .ev_arb_lost(ev_arb_lost), .ev_addr_match(ev_addr_match),
    .ev_gen_call(ev_gen_call), .bus_busy(bus_busy), .is_master(is_master));
  i2c_slave_model u_i2c_slave_model (.scl(scl), .sda(sda), .stretch(stretch),
    .sda_low(m_sda_low), .scl_low(m_scl_low));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (ev_addr_match) n_match++;
    if (ev_gen_call) n_gc++;
    if (rx_valid) n_rx++;
    if (ev_arb_lost) n_arb++;
    if (cyc == 80000) begin
      error_cnt++;
      results();
    end
  end

  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk1(input logic got, input logic exp, input string msg);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t %s got %b", $time, msg, got);
    end
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string msg);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic clk(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // fifo words go in back to back; anything offered while full is dropped
  task automatic pushq(input logic [7:0] q[$]);
    foreach (q[i]) begin
      tx_data = q[i];
      tx_valid = 1'b1;
      clk(1);
    end
    tx_valid = 1'b0;
  endtask
  // stop is asked for only once the last byte's ack has been seen
  task automatic mrun(input int n);
    int k;
    k = 0;
    go = 1'b1;
    while (k < n && cyc < 80000) begin
      clk(1);
      if (is_master) go = 1'b0;
      if (ev_byte) k++;
    end
    stop_req = 1'b1;
    while ((bus_busy || is_master) && cyc < 80000) clk(1);
    stop_req = 1'b0;
    go = 1'b0;
  endtask
  // bench-side master, 160 ns bit time, waits out any stretching
  task automatic mbit(input logic b, output logic r);
    tb_sda_low = !b;
    #40 tb_scl_low = 1'b0;
    wait (scl);
    #40 r = sda;
    #40 tb_scl_low = 1'b1;
    #40;
  endtask
  task automatic mbyte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) mbit(b[i], r);
    mbit(1'b1, r);
    ack = !r;
  endtask
  task automatic mstart;
    tb_sda_low = 1'b0;
    tb_scl_low = 1'b0;
    #80 tb_sda_low = 1'b1;
    #80 tb_scl_low = 1'b1;
  endtask
  task automatic mstop;
    tb_sda_low = 1'b1;
    #80 tb_scl_low = 1'b0;
    #80 tb_sda_low = 1'b0;
    #80;
  endtask

  task automatic t_reset;
    chk1(tx_ready, 1'b1, "ready after reset");
    chk1(scl_oe | sda_oe | is_master | bus_busy, 1'b0, "idle after reset");
    chk1(scl_o | sda_o, 1'b0, "line out level");
    $display("done reset");
  endtask
  task automatic t_fill;
    logic [7:0] exp_q[$];
    exp_q = '{8'ha4, 8'h80, 8'h01, 8'h7e, 8'hc3, 8'h3c, 8'hff, 8'h00};
    spd = 2'h1;
    stretch = 1'b1;
    pushq('{8'ha4, 8'h80, 8'h01, 8'h7e, 8'hc3, 8'h3c, 8'hff, 8'h00, 8'hee});
    chk1(tx_ready, 1'b0, "fifo full");
    mrun(8);
    chk8(8'(u_i2c_slave_model.got.size()), 8'h08, "byte count");
    foreach (u_i2c_slave_model.got[i])
      chk8(u_i2c_slave_model.got[i], exp_q[i], "sent byte");
    $display("done fill");
  endtask
  task automatic t_wr_nack;
    spd = 2'h0;
    stretch = 1'b0;
    pushq('{8'h58});
    mrun(1);
    chk1(ack_rcvd, 1'b0, "nack seen");
    chk8(8'(u_i2c_slave_model.got.size()), 8'h00, "no bytes");
    $display("done nack");
  endtask
  task automatic t_busy;
    spd = 2'h2;
    mstart;
    chk1(bus_busy, 1'b1, "busy after start");
    pushq('{8'ha4, 8'h5a});
    go = 1'b1;
    clk(300);
    chk1(is_master | scl_oe, 1'b0, "held off while busy");
    mstop;
    mrun(2);
    chk1(ack_rcvd, 1'b1, "ack seen");
    chk8(u_i2c_slave_model.got[1], 8'h5a, "data byte");
    $display("done busy");
  endtask
  task automatic t_slave;
    logic a;
    int m0;
    int g0;
    int r0;
    m0 = n_match;
    g0 = n_gc;
    r0 = n_rx;
    mstart;
    mbyte({7'h2d, 1'b0}, a);
    chk1(a, 1'b1, "own addr ack");
    mbyte(8'hc3, a);
    chk1(a, 1'b1, "data ack");
    mstop;
    chk8(rx_data, 8'hc3, "slave rx byte");
    chk1(n_match == m0 + 1, 1'b1, "match event");
    mstart;
    mbyte({7'h2e, 1'b0}, a);
    chk1(a, 1'b0, "foreign addr");
    mstop;
    mstart;
    mbyte(8'h00, a);
    chk1(a, 1'b1, "broadcast ack");
    mstop;
    chk1(n_gc == g0 + 1, 1'b1, "broadcast event");
    chk1(n_rx == r0 + 4, 1'b1, "received byte pulses");
    chk1(bus_busy, 1'b0, "free after stop");
    $display("done slave");
  endtask
  // bench holds sda low while the engine sends a one: the engine must lose the bus
  task automatic t_arb;
    int a0;
    int w;
    a0 = n_arb;
    pushq('{8'ha4});
    go = 1'b1;
    while (!scl_oe && cyc < 80000) clk(1);
    go = 1'b0;
    clk(20);
    tb_sda_low = 1'b1;
    w = 0;
    while (n_arb == a0 && w < 200) begin
      clk(1);
      w++;
    end
    chk1(n_arb == a0 + 1, 1'b1, "arbitration lost");
    chk1(is_master | scl_oe, 1'b0, "dropped to slave");
    clk(20);
    tb_sda_low = 1'b0;
    clk(20);
    chk1(bus_busy, 1'b0, "free after release");
    $display("done arb");
  endtask
  task automatic t_disable;
    pushq('{8'ha4, 8'h11});
    go = 1'b1;
    while (!is_master && cyc < 80000) clk(1);
    clk(200);
    enable = 1'b0;
    clk(4);
    chk1(scl_oe | sda_oe | is_master, 1'b0, "released when off");
    $display("done disable");
  endtask

  initial begin
    rst_n = 1'b0;
    enable = 1'b1;
    spd = 2'h2;
    own_addr = 7'h2d;
    {go, stop_req, restart_req, nack_next, tx_valid, stretch} = 6'h00;
    tx_data = 8'h00;
    {tb_sda_low, tb_scl_low} = 2'h0;
    clk(6);
    rst_n = 1'b1;
    clk(1);
    t_reset();
    t_fill();
    t_wr_nack();
    t_busy();
    t_slave();
    t_arb();
    t_disable();
    results();
  end
endmodule
